// ==== core/bdg_top.sv ====
// buffered digital i/o top: four port groups, nine counters, interrupt logic
// assumes a host bridge giving decoded byte offsets within a 32-byte window
//
// Functional notes
// R01 - 96 lines in four 24-bit groups, nibble and byte ports selectable.
// R02 - each group has two byte ports and port c split into nibbles.
// R03 - software sets each port input or output via the group control byte.
// R04 - line-buffer direction follows each port's programmed direction automatically.
// R05 - after reset all buffers are enabled, none floated.
// R06 - software may also float and re-enable the buffers.
// R07 - one line per digital group, one counter per counter group interrupt.
// R08 - each interrupt source is gated by a static strap input.
// R09 - decodes 32 consecutive byte addresses from a system base.
// R10 - nine gated 16-bit counters, three per counter group.
// R11 - counters advance on the falling edge of their count clock.
// R12 - on-board 1 MHz source selectable by strap as clock or gate.
// R13 - rising edge on port c bit 3 latches the group interrupt.
// R14 - irq off at reset; write 1F clears and enables, 1E clears, disables.
// R15 - reading 1E/1F returns latches in bits 0-6, global enable bit 7.
// R16 - write 1C bit 0 arms tristate: output mode floats, data write restores.
// R17 - irq high while enabled and any latch left unmasked by the 1D source enable is set.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bdg_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [bdg_pkg::ADDR_W-1:0] addr,
  input wire logic [bdg_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [bdg_pkg::DATA_W-1:0] rdata,
  input wire logic [bdg_pkg::NUM_GROUPS-1:0][bdg_pkg::GROUP_W-1:0] dio_in,
  output logic [bdg_pkg::NUM_GROUPS-1:0][bdg_pkg::GROUP_W-1:0] dio_out,
  output logic [bdg_pkg::NUM_GROUPS-1:0][bdg_pkg::GROUP_W-1:0] dio_oe,
  input wire logic [bdg_pkg::NUM_CNT-1:0] cnt_ext_clk,
  input wire logic [bdg_pkg::NUM_CNT-1:0] cnt_ext_gate,
  input wire logic [bdg_pkg::NUM_CNT-1:0] cnt_clk_strap,
  input wire logic [bdg_pkg::NUM_CNT-1:0] cnt_gate_strap,
  output logic [bdg_pkg::NUM_CNT-1:0] cnt_out,
  input wire logic [bdg_pkg::NUM_SRC-1:0] irq_source_strap,
  output logic irq
);
  import bdg_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic [6:0] latch;
    logic [6:0] src_en;
    logic glob_en;
    logic tri_arm;
    logic [6:0] src_prev;
    logic [4:0] osc_div;
    logic osc;
  } bdg_top_s;

  bdg_top_s st_reg;
  bdg_top_s st_next;

  logic [NUM_GROUPS-1:0][7:0] grp_rd;
  logic [NUM_GROUPS-1:0] grp_c3;
  logic [NUM_CNT-1:0][7:0] cnt_rd;
  logic [NUM_CNT-1:0] cnt_clk_mux;
  logic [NUM_CNT-1:0] cnt_gate_mux;
  logic [NUM_CNT-1:0] cnt_wr;
  logic [NUM_CNT-1:0] cnt_rdp;
  logic [NUM_CNT-1:0] cnt_ptr_rst;
  logic [NUM_SRC-1:0] src_now;
  logic [NUM_SRC-1:0] src_event;
  logic is_dio;
  logic is_cnt;
  logic [1:0] cgrp;
  logic [3:0] cnt_idx;
  logic irq_clear;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  // all 32 offsets are taken, so no access is ever unanswered
  assign is_dio = (addr < OFF_CNT_BASE); // R09
  assign is_cnt = (addr >= OFF_CNT_BASE) && (addr < OFF_TRI_ARM);
  assign cgrp = 2'(addr[3:2]);
  assign cnt_idx = 4'(cgrp * 3) + {2'b00, addr[1:0]};
  assign irq_clear = wr_stb && (addr == OFF_IRQ_ON || addr == OFF_IRQ_OFF); // R14

  // -----------------------------------------------------------------
  // digital groups
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_grp
      bdg_port_group u_grp (
        .clk(clk),
        .rst(rst),
        .wr(wr_stb && is_dio && addr[3:2] == gi), // R01
        .sel(addr[1:0]),
        .wdata(wdata),
        .tri_arm(st_reg.tri_arm),
        .pin_in(dio_in[gi]),
        .pin_out(dio_out[gi]),
        .pin_oe(dio_oe[gi]),
        .rd_byte(grp_rd[gi]),
        .c3_level(grp_c3[gi])
      );
      assign src_now[gi] = grp_c3[gi]; // R07
    end
  endgenerate

  // -----------------------------------------------------------------
  // counters
  // -----------------------------------------------------------------
  genvar ci;
  generate
    for (ci = 0; ci < NUM_CNT; ci++) begin : g_cnt
      // strap picks the on-board oscillator over the external pin
      assign cnt_clk_mux[ci] = cnt_clk_strap[ci] ? st_reg.osc : cnt_ext_clk[ci]; // R12
      assign cnt_gate_mux[ci] = cnt_gate_strap[ci] ? st_reg.osc : cnt_ext_gate[ci]; // R12
      assign cnt_wr[ci] = wr_stb && is_cnt && addr[1:0] != SEL_CTL && cnt_idx == ci;
      assign cnt_rdp[ci] = rd_stb && is_cnt && addr[1:0] != SEL_CTL && cnt_idx == ci;
      // control byte of a counter group restarts the byte order of its three
      assign cnt_ptr_rst[ci] = wr_stb && is_cnt && addr[1:0] == SEL_CTL && cgrp == ci / 3;
      bdg_counter u_cnt (
        .clk(clk),
        .rst(rst),
        .wr(cnt_wr[ci]),
        .rd(cnt_rdp[ci]),
        .ptr_rst(cnt_ptr_rst[ci]),
        .wdata(wdata),
        .cnt_clk(cnt_clk_mux[ci]),
        .cnt_gate(cnt_gate_mux[ci]),
        .rd_byte(cnt_rd[ci]),
        .cnt_out(cnt_out[ci])
      ); // R10
    end
    for (ci = 0; ci < NUM_CGROUPS; ci++) begin : g_csrc
      assign src_now[NUM_GROUPS + ci] = cnt_out[ci * 3 + CNT_IRQ_IDX]; // R07
    end
  endgenerate

  // rising edges of strapped sources only; an open strap never latches
  assign src_event = src_now & ~st_reg.src_prev & irq_source_strap; // R08 R13

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.src_prev = src_now;
    // free-running 1 MHz square wave
    if (st_reg.osc_div == OSC_HALF_LAST) begin
      st_next.osc_div = 5'h00;
      st_next.osc = ~st_reg.osc;
    end else begin
      st_next.osc_div = st_reg.osc_div + 5'h01;
    end
    // a new edge in the clearing cycle survives the clear
    st_next.latch = (irq_clear ? 7'h00 : st_reg.latch) | src_event; // R14
    if (wr_stb) begin
      case (addr)
        OFF_TRI_ARM: st_next.tri_arm = wdata[TRI_ARM_BIT]; // R16
        OFF_SRC_EN: st_next.src_en = wdata[6:0];
        OFF_IRQ_ON: st_next.glob_en = 1'b1; // R14
        OFF_IRQ_OFF: st_next.glob_en = 1'b0; // R14
        default: st_next.glob_en = st_reg.glob_en;
      endcase
    end
    // read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (rd_stb) begin
      if (is_dio) begin
        st_next.rdata = grp_rd[addr[3:2]];
      end else if (is_cnt) begin
        st_next.rdata = (addr[1:0] == SEL_CTL) ? 8'h00 : cnt_rd[cnt_idx];
      end else begin
        case (addr)
          OFF_TRI_ARM: st_next.rdata = {7'h00, st_reg.tri_arm};
          OFF_SRC_EN: st_next.rdata = {1'b0, st_reg.src_en};
          default: st_next.rdata = {st_reg.glob_en, st_reg.latch}; // R15
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // edge history starts high: pulled-up idle lines must not look like a rise
      st_reg <= '{rdata: 8'h00, latch: 7'h00, src_en: SRC_EN_RST, glob_en: 1'b0,
                  tri_arm: 1'b0, src_prev: '1, osc_div: 5'h00, osc: 1'b0}; // R14
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign irq = st_reg.glob_en && |(st_reg.latch & st_reg.src_en); // R17
endmodule : bdg_top
`default_nettype wire

// ==== core/bdg_pkg.sv ====
// constants, register map and field layout of the buffered digital i/o block
// assumes a 50 MHz host clock and an 8-bit register port of 32 byte addresses
package bdg_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  // half period of the on-board counter oscillator, in host clocks
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam logic [4:0] OSC_HALF_LAST = 5'(OSC_HALF_CYC - 1);

  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned GROUP_W = 24;
  localparam int unsigned NUM_CGROUPS = 3;
  localparam int unsigned NUM_CNT = 9;
  localparam int unsigned NUM_SRC = 7;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;

  // register map
  localparam logic [4:0] OFF_CNT_BASE = 5'h10;
  localparam logic [4:0] OFF_SRC_EN = 5'h1D;
  localparam logic [4:0] OFF_TRI_ARM = 5'h1C;
  localparam logic [4:0] OFF_IRQ_OFF = 5'h1E;
  localparam logic [4:0] OFF_IRQ_ON = 5'h1F;
  // register select within a four-byte window
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  localparam logic [1:0] SEL_CTL = 2'h3;

  // control byte of a parallel_port_interface
  localparam int unsigned CTL_MODE_SET = 7;
  localparam int unsigned CTL_A_IN = 4;
  localparam int unsigned CTL_CH_IN = 3;
  localparam int unsigned CTL_B_IN = 1;
  localparam int unsigned CTL_CL_IN = 0;
  localparam int unsigned CTL_BIT_LSB = 1;
  localparam int unsigned CTL_BIT_VAL = 0;
  localparam int unsigned TRI_ARM_BIT = 0;
  // port c bit that feeds the group interrupt
  localparam int unsigned C_IRQ_BIT = 3;
  // index of the counter inside a counter group that feeds the interrupt
  localparam int unsigned CNT_IRQ_IDX = 2;

  // reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [6:0] SRC_EN_RST = 7'h7F;
  localparam logic [15:0] CNT_RST = 16'h0000;
endpackage : bdg_pkg

// ==== core/bdg_port_group.sv ====
// one 24-line digital group: ports a, b, c (two nibbles) and a control byte
// assumes register strobes are already decoded for this group's four bytes
`timescale 1ns/100ps
`default_nettype none
module bdg_port_group (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  input wire logic tri_arm,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic [7:0] rd_byte,
  output logic c3_level
);
  import bdg_pkg::*;

  typedef struct packed {
    logic [7:0] a_out;
    logic [7:0] b_out;
    logic [7:0] c_out;
    logic a_in;
    logic b_in;
    logic ch_in;
    logic cl_in;
    logic [3:0] flt;  // {ch, cl, b, a} buffer floated
  } bdg_grp_s;

  bdg_grp_s st_reg;
  bdg_grp_s st_next;
  logic [7:0] c_view;
  logic [7:0] c_oe;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (wr) begin
      case (sel)
        SEL_A: begin
          st_next.a_out = wdata;
          st_next.flt[0] = 1'b0; // R16
        end
        SEL_B: begin
          st_next.b_out = wdata;
          st_next.flt[1] = 1'b0; // R16
        end
        SEL_C: begin
          st_next.c_out = wdata;
          st_next.flt[3:2] = 2'b00; // R16
        end
        SEL_CTL: begin
          if (wdata[CTL_MODE_SET]) begin
            // mode set clears every output latch, as a fresh port would
            st_next.a_out = DIR_RST;
            st_next.b_out = DIR_RST;
            st_next.c_out = DIR_RST;
            st_next.a_in = wdata[CTL_A_IN]; // R03
            st_next.b_in = wdata[CTL_B_IN]; // R03
            st_next.ch_in = wdata[CTL_CH_IN]; // R03
            st_next.cl_in = wdata[CTL_CL_IN]; // R03
            // armed tristate floats every port just made an output
            st_next.flt[0] = tri_arm & ~wdata[CTL_A_IN]; // R16
            st_next.flt[1] = tri_arm & ~wdata[CTL_B_IN]; // R16
            st_next.flt[2] = tri_arm & ~wdata[CTL_CL_IN]; // R16
            st_next.flt[3] = tri_arm & ~wdata[CTL_CH_IN]; // R16
          end else begin
            // single-bit set/reset of port c counts as writing that nibble
            st_next.c_out[wdata[CTL_BIT_LSB +: 3]] = wdata[CTL_BIT_VAL];
            st_next.flt[wdata[CTL_BIT_LSB + 2] ? 3 : 2] = 1'b0; // R16
          end
        end
        default: begin
          st_next = st_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // all ports input, all buffers enabled
      st_reg <= '{a_out: DIR_RST, b_out: DIR_RST, c_out: DIR_RST, a_in: 1'b1,
                  b_in: 1'b1, ch_in: 1'b1, cl_in: 1'b1, flt: 4'h0}; // R05
    end else begin
      st_reg <= st_next;
    end
  end

  // -----------------------------------------------------------------
  // line buffers and readback
  // -----------------------------------------------------------------
  assign c_oe = {{4{~st_reg.ch_in & ~st_reg.flt[3]}}, {4{~st_reg.cl_in & ~st_reg.flt[2]}}};
  // buffer direction follows the programmed port direction
  assign pin_oe = {c_oe, {8{~st_reg.b_in & ~st_reg.flt[1]}},
                   {8{~st_reg.a_in & ~st_reg.flt[0]}}}; // R04 R06
  assign pin_out = {st_reg.c_out, st_reg.b_out, st_reg.a_out}; // R02
  assign c_view = {st_reg.ch_in ? pin_in[23:20] : st_reg.c_out[7:4],
                   st_reg.cl_in ? pin_in[19:16] : st_reg.c_out[3:0]};
  // the latch when driven, else the line itself, so software toggles count
  assign c3_level = c_oe[C_IRQ_BIT] ? st_reg.c_out[C_IRQ_BIT] : pin_in[16 + C_IRQ_BIT]; // R13

  always_comb begin
    case (sel)
      SEL_A: rd_byte = st_reg.a_in ? pin_in[7:0] : st_reg.a_out;
      SEL_B: rd_byte = st_reg.b_in ? pin_in[15:8] : st_reg.b_out;
      SEL_C: rd_byte = c_view;
      default: rd_byte = {1'b1, 2'b00, st_reg.a_in, st_reg.ch_in, 1'b0, st_reg.b_in,
                          st_reg.cl_in};
    endcase
  end
endmodule : bdg_port_group
`default_nettype wire

// ==== core/bdg_counter.sv ====
// one 16-bit down counter, loaded low byte then high byte
// assumes count clock and gate are synchronous to clk and well below its rate
`timescale 1ns/100ps
`default_nettype none
module bdg_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic ptr_rst,
  input wire logic [7:0] wdata,
  input wire logic cnt_clk,
  input wire logic cnt_gate,
  output logic [7:0] rd_byte,
  output logic cnt_out
);
  import bdg_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] lo_hold;
    logic wr_hi;
    logic rd_hi;
    logic armed;
    logic out;
    logic clk_prev;
  } bdg_cnt_s;

  bdg_cnt_s st_reg;
  bdg_cnt_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = cnt_clk;
    // count on the falling edge of the count clock
    if (st_reg.armed && cnt_gate && st_reg.clk_prev && !cnt_clk) begin // R11
      st_next.count = st_reg.count - 16'h0001;
      if (st_reg.count == 16'h0001) begin
        st_next.out = 1'b1;
      end
    end
    if (wr) begin
      if (st_reg.wr_hi) begin
        st_next.count = {wdata, st_reg.lo_hold};
        st_next.armed = 1'b1;
        st_next.out = 1'b0;
        st_next.wr_hi = 1'b0;
      end else begin
        st_next.lo_hold = wdata;
        st_next.wr_hi = 1'b1;
      end
    end
    if (rd) begin
      st_next.rd_hi = ~st_reg.rd_hi;
    end
    if (ptr_rst) begin
      st_next.wr_hi = 1'b0;
      st_next.rd_hi = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{count: CNT_RST, lo_hold: 8'h00, wr_hi: 1'b0, rd_hi: 1'b0,
                  armed: 1'b0, out: 1'b0, clk_prev: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_byte = st_reg.rd_hi ? st_reg.count[15:8] : st_reg.count[7:0];
  assign cnt_out = st_reg.out;
endmodule : bdg_counter
`default_nettype wire

// ==== tb/bdg_sva.sv ====
// checker of the register port, buffer enables and interrupt output
// assumes it is bound into bdg_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module bdg_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [bdg_pkg::ADDR_W-1:0] addr,
  input wire logic [bdg_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [bdg_pkg::DATA_W-1:0] rdata,
  input wire logic [bdg_pkg::NUM_GROUPS-1:0][bdg_pkg::GROUP_W-1:0] dio_out,
  input wire logic [bdg_pkg::NUM_GROUPS-1:0][bdg_pkg::GROUP_W-1:0] dio_oe,
  input wire logic [bdg_pkg::NUM_CNT-1:0] cnt_out,
  input wire logic irq
);
  import bdg_pkg::*;
  logic arm_reg;
  logic glob_reg;
  logic ctl_wr;
  logic [1:0] g;
  assign g = addr[3:2];
  assign ctl_wr = wr_stb && !addr[4] && addr[1:0] == SEL_CTL && wdata[CTL_MODE_SET];
  // ----------------------------------------
  // shadow of arm and global enable
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_reg <= 1'b0;
      glob_reg <= 1'b0;
    end else if (wr_stb) begin
      if (addr == OFF_TRI_ARM) arm_reg <= wdata[TRI_ARM_BIT];
      if (addr == OFF_IRQ_ON) glob_reg <= 1'b1;
      if (addr == OFF_IRQ_OFF) glob_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |-> dio_oe == '0 && dio_out == '0 && !irq && rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  property p_rd_idle;
    !$past(rd_stb) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_cnt_ctl;
    rd_stb && addr == 5'h13 |=> rdata == 8'h00;
  endproperty
  a_cnt_ctl: assert property (p_cnt_ctl) else $error("counter ctl read not zero");
  property p_stat;
    rd_stb && addr[4:1] == 4'hF |=> rdata[7] == $past(glob_reg);
  endproperty
  a_stat: assert property (p_stat) else $error("status enable bit wrong");
  property p_irq_glob;
    irq |-> glob_reg;
  endproperty
  a_irq_glob: assert property (p_irq_glob) else $error("irq while disabled");
  property p_mask;
    wr_stb && addr == OFF_SRC_EN && wdata == 8'h00 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with all sources masked");
  property p_out_all;
    ctl_wr && wdata == 8'h80 && !arm_reg |=> dio_oe[$past(g)] == '1 && dio_out[$past(g)] == '0;
  endproperty
  a_out_all: assert property (p_out_all) else $error("output mode not driven");
  property p_in_all;
    ctl_wr && wdata == 8'h9B |=> dio_oe[$past(g)] == '0;
  endproperty
  a_in_all: assert property (p_in_all) else $error("input mode still driven");
  property p_float;
    ctl_wr && wdata == 8'h80 && arm_reg |=> dio_oe[$past(g)] == '0;
  endproperty
  a_float: assert property (p_float) else $error("armed port not floated");
  property p_latch;
    wr_stb && !addr[4] && addr[1:0] == SEL_A && dio_oe[g][7:0] == 8'hFF
      |=> dio_out[$past(g)][7:0] == $past(wdata);
  endproperty
  a_latch: assert property (p_latch) else $error("port a latch not written");
  c_irq: cover property ($rose(irq));
  c_float: cover property (ctl_wr && arm_reg);
  c_cnt: cover property ($rose(cnt_out[2]));
endmodule : bdg_sva
bind bdg_top bdg_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dio_out(dio_out),
  .dio_oe(dio_oe), .cnt_out(cnt_out), .irq(irq));
`default_nettype wire

// ==== tb/bdg_field.sv ====
// field side of the digital lines: input modules and pull-ups
// assumes the bench chooses which lines a module drives
`timescale 1ns/100ps
`default_nettype none
module bdg_field (
  input wire logic [3:0][23:0] dio_out,
  input wire logic [3:0][23:0] dio_oe,
  input wire logic [3:0][23:0] fdrv,
  input wire logic [3:0][23:0] fval,
  output logic [3:0][23:0] dio_in
);
  // undriven lines float up through the pull-ups
  assign dio_in = (dio_oe & dio_out) | (~dio_oe & fdrv & fval) | (~dio_oe & ~fdrv);
endmodule : bdg_field
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of bdg_top
// assumes bdg_field on the lines and bdg_sva bound into the design
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bdg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic [4:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic irq;
  logic [3:0][23:0] dio_in, dio_out, dio_oe;
  logic [3:0][23:0] fdrv = '1;
  logic [3:0][23:0] fval = {4{24'h3C6996}};
  logic [8:0] cnt_ext_clk = '0, cnt_ext_gate = '1, cnt_clk_strap = 9'h001;
  logic [8:0] cnt_gate_strap = '0, cnt_out;
  logic [6:0] irq_source_strap = 7'h7F;
  int errors = 0;
  int checks = 0;
  always #10 clk = ~clk;
  bdg_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
    .cnt_ext_clk(cnt_ext_clk), .cnt_ext_gate(cnt_ext_gate), .cnt_clk_strap(cnt_clk_strap),
    .cnt_gate_strap(cnt_gate_strap), .cnt_out(cnt_out),
    .irq_source_strap(irq_source_strap), .irq(irq));
  bdg_field u_fld (.dio_out(dio_out), .dio_oe(dio_oe), .fdrv(fdrv), .fval(fval),
    .dio_in(dio_in));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic [23:0] exp_oe(input logic [7:0] c);
    return {{4{~c[3]}}, {4{~c[0]}}, {8{~c[1]}}, {8{~c[4]}}};
  endfunction : exp_oe
  task automatic sw_edge();
    wr(5'h03, 8'h06);
    wr(OFF_IRQ_ON, 8'h00);
    wr(5'h03, 8'h07);
    cyc(3);
  endtask : sw_edge
  task automatic ck_fall();
    @(posedge clk);
    cnt_ext_clk[2] <= 1'b1;
    cyc(3);
    @(posedge clk);
    cnt_ext_clk[2] <= 1'b0;
    cyc(4);
  endtask : ck_fall
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int g = 0; g < 4; g++) begin
      chk("dio_oe", 24'h0, dio_oe[g]);
      chk("dio_out", 24'h0, dio_out[g]);
    end
    chk("irq", 24'h0, 24'(irq));
    rd(OFF_IRQ_ON, d);
    chk("status", 24'h00, 24'(d));
    rd(OFF_SRC_EN, d);
    chk("src_en", 24'h7F, 24'(d));
    rd(OFF_TRI_ARM, d);
    chk("arm", 24'h00, 24'(d));
    rd(5'h13, d);
    chk("cnt_ctl", 24'h00, 24'(d));
    $display("test reset done");
  endtask : t_reset
  task automatic t_dir();
    logic [7:0] tbl [6] = '{8'h80, 8'h90, 8'h82, 8'h88, 8'h81, 8'h9B};
    logic [7:0] c;
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 6; k++) begin
        c = tbl[k];
        wr(5'(4 * g + 3), c);
        chk("dio_oe", exp_oe(c), dio_oe[g]);
        wr(5'(4 * g), 8'h5A);
        rd(5'(4 * g), d);
        chk("port_a", c[4] ? 24'(fval[g][7:0]) : 24'h5A, 24'(d));
        rd(5'(4 * g + 3), d);
        chk("ctl", 24'(c & 8'h9B), 24'(d));
      end
    end
    $display("test dir done");
  endtask : t_dir
  task automatic t_tri();
    wr(OFF_TRI_ARM, 8'h01);
    rd(OFF_TRI_ARM, d);
    chk("arm", 24'h01, 24'(d));
    wr(5'h07, 8'h80);
    chk("dio_oe", 24'h0, dio_oe[1]);
    wr(5'h04, 8'h11);
    chk("dio_oe", 24'h0000FF, dio_oe[1]);
    wr(5'h06, 8'h22);
    chk("dio_oe", 24'hFF00FF, dio_oe[1]);
    wr(OFF_TRI_ARM, 8'h00);
    wr(5'h07, 8'h80);
    chk("dio_oe", 24'hFFFFFF, dio_oe[1]);
    $display("test tri done");
  endtask : t_tri
  task automatic t_irq();
    wr(5'h0B, 8'h9B);
    wr(OFF_IRQ_ON, 8'h00);
    @(posedge clk);
    fval[2][19] <= 1'b0;
    cyc(3);
    @(posedge clk);
    fval[2][19] <= 1'b1;
    cyc(4);
    chk("irq", 24'h1, 24'(irq));
    rd(OFF_IRQ_OFF, d);
    chk("status", 24'h84, 24'(d));
    wr(OFF_IRQ_OFF, 8'h00);
    chk("irq", 24'h0, 24'(irq));
    rd(OFF_IRQ_ON, d);
    chk("status", 24'h00, 24'(d));
    wr(5'h03, 8'h80);
    sw_edge();
    chk("irq", 24'h1, 24'(irq));
    rd(OFF_IRQ_ON, d);
    chk("status", 24'h81, 24'(d));
    @(posedge clk);
    irq_source_strap <= 7'h7E;
    sw_edge();
    rd(OFF_IRQ_ON, d);
    chk("status", 24'h80, 24'(d));
    chk("irq", 24'h0, 24'(irq));
    @(posedge clk);
    irq_source_strap <= 7'h7F;
    wr(OFF_SRC_EN, 8'h00);
    sw_edge();
    chk("irq", 24'h0, 24'(irq));
    wr(OFF_SRC_EN, 8'h7F);
    chk("irq", 24'h1, 24'(irq));
    wr(OFF_IRQ_OFF, 8'h00);
    $display("test irq done");
  endtask : t_irq
  task automatic t_cnt();
    wr(OFF_IRQ_ON, 8'h00);
    wr(5'h13, 8'h00);
    wr(5'h12, 8'h02);
    wr(5'h12, 8'h00);
    wr(5'h10, 8'h03);
    wr(5'h10, 8'h00);
    cyc(20);
    chk("osc_cnt", 24'h0, 24'(cnt_out[0]));
    rd(5'h12, d);
    chk("cnt_lo", 24'h02, 24'(d));
    rd(5'h12, d);
    chk("cnt_hi", 24'h00, 24'(d));
    @(posedge clk);
    cnt_ext_gate[2] <= 1'b0;
    ck_fall();
    chk("cnt_out", 24'h0, 24'(cnt_out[2]));
    @(posedge clk);
    cnt_ext_gate[2] <= 1'b1;
    ck_fall();
    chk("cnt_out", 24'h0, 24'(cnt_out[2]));
    ck_fall();
    chk("cnt_out", 24'h1, 24'(cnt_out[2]));
    chk("irq", 24'h1, 24'(irq));
    rd(OFF_IRQ_OFF, d);
    chk("status", 24'h90, 24'(d));
    cyc(250);
    chk("osc_cnt", 24'h1, 24'(cnt_out[0]));
    wr(OFF_IRQ_OFF, 8'h00);
    $display("test cnt done");
  endtask : t_cnt
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    // a real rising edge on rst, so the async reset acts before the first clock
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_dir();
    t_tri();
    t_irq();
    t_cnt();
    end_of_test();
  end
  // whole run is well under a thousand cycles
  initial begin
    #1_000_000;
    errors++;
    $display("unexpected watchdog expired");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
